// File: rtl/supply_excursion_detector.sv
// control and event logic of the supply excursion detector
// Behaviour
// - The detector runs only while the power-enable bit is set.
// - A read-only ready flag rises after a settle interval on each enable.
// - The event flag cannot set until the ready flag is set.
// - Direction clear watches for falls, set watches for rises.
// - Reaching the trip level exactly counts as an event only when watching for rises.
// - A four-bit level field picks one of sixteen settings, 0 low, 14 high.
// - Level all ones selects the external detect input pin.
// - A qualifying event sets the event flag in the second flag register.
// - The request reaches the core only with event, periph, global enables.
// - Bit 6 of the control register reads zero and ignores writes.
// - The settle interval is a fixed clock count, SETTLE_CYCLES, not a measured time.
// - The event flag is eligible only after the settle time has passed.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module supply_excursion_detector #(
  parameter int SETTLE_CYCLES = vdet_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // analog front end
  input wire logic trip_compare_i,
  input wire logic ext_compare_i,
  output logic detector_power_enable_o,
  output logic [3:0] trip_level_field_o,
  output logic external_select_o,
  output logic excursion_direction_select_o,
  // interrupts
  output logic voltage_event_req_o,
  output logic irq_o
);
  // settle sequencer states
  typedef enum logic [1:0] {
    DET_OFF,
    DET_SETTLING,
    DET_ARMED
  } det_state_e;

  // software visible registers
  logic [7:0] voltage_detect_control;
  logic [7:0] periph_flag_reg_two;
  logic [7:0] periph_enable_reg_two;
  logic [7:0] core_interrupt_control;
  logic [vdet_pkg::ST_W-1:0] status;
  logic [vdet_pkg::ST_W-1:0] mask;

  // settle sequencer
  det_state_e det_state;
  logic [31:0] settle_cnt;
  logic reference_ready_flag;
  logic ready_q;

  // comparator path
  logic trip_sync;
  logic ext_sync;

  // decoded fields and event qualification
  logic power_en;
  logic direction;
  logic [3:0] level;
  logic above;
  logic hit;
  logic event_set;
  logic ready_rise;

  // register write strobes
  logic wr_ctl;
  logic wr_flags;
  logic wr_status;
  logic wr_enables;
  logic wr_core;
  logic wr_mask;

  // one register-port strobe aimed at one index
  function automatic logic bus_hit(input logic strobe,
                                   input logic [2:0] addr,
                                   input logic [2:0] index);
    return strobe && (addr == index);
  endfunction : bus_hit

  // all-ones level hands the comparator to the external pin
  function automatic logic is_external(input logic [3:0] lvl);
    return lvl == vdet_pkg::LEVEL_EXTERNAL;
  endfunction : is_external

  // settle interval over once the count reaches its end point
  function automatic logic settle_done(input logic [31:0] cnt);
    return cnt >= 32'(SETTLE_CYCLES - 1);
  endfunction : settle_done

  // control readback: spare bit reads low, ready comes from the sequencer
  function automatic logic [7:0] control_view(input logic [7:0] ctl,
                                              input logic ready);
    logic [7:0] view;
    view = ctl & vdet_pkg::CONTROL_WMASK;
    view[vdet_pkg::READY_BIT] = ready;
    view[vdet_pkg::UNUSED_BIT] = 1'b0;
    return view;
  endfunction : control_view

  assign power_en = voltage_detect_control[vdet_pkg::POWER_BIT];
  assign direction = voltage_detect_control[vdet_pkg::DIR_BIT];
  assign level = voltage_detect_control[vdet_pkg::LEVEL_LSB +:
                                        vdet_pkg::LEVEL_W];

  // write strobes decoded per register
  assign wr_ctl = bus_hit(reg_wr_i, reg_addr_i, vdet_pkg::ADDR_CONTROL);
  assign wr_flags = bus_hit(reg_wr_i, reg_addr_i, vdet_pkg::ADDR_FLAGS);
  assign wr_enables = bus_hit(reg_wr_i, reg_addr_i, vdet_pkg::ADDR_ENABLES);
  assign wr_core = bus_hit(reg_wr_i, reg_addr_i, vdet_pkg::ADDR_CORE);
  assign wr_status = bus_hit(reg_wr_i, reg_addr_i, vdet_pkg::ADDR_STATUS);
  assign wr_mask = bus_hit(reg_wr_i, reg_addr_i, vdet_pkg::ADDR_MASK);

  // comparator results cross into the clock domain
  vdet_sync u_trip_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(trip_compare_i),
    .sync_o(trip_sync)
  );
  vdet_sync u_ext_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ext_compare_i),
    .sync_o(ext_sync)
  );

  // comparator high means supply at or above the trip point
  assign above = is_external(level) ? ext_sync
                                    : trip_sync;
  // equality counts only for rises, since the analog side reports ties as above
  assign hit = direction ? above : !above;
  assign event_set = power_en && reference_ready_flag && hit;

  // control register; ready and unused bits are not writable
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      voltage_detect_control <= vdet_pkg::CONTROL_RESET;
    end else if (wr_ctl) begin
      voltage_detect_control <= reg_wdata_i & vdet_pkg::CONTROL_WMASK;
    end
  end

  // settle sequencer restarts on every enable; counts SETTLE_CYCLES clocks, not a fixed time
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      det_state <= DET_OFF;
      settle_cnt <= 32'h0;
    end else if (!power_en) begin
      det_state <= DET_OFF;
      settle_cnt <= 32'h0;
    end else begin
      case (det_state)
        DET_OFF: begin
          // the enabling edge already counts as the first settle cycle
          settle_cnt <= 32'h1;
          det_state <= settle_done(32'h0) ? DET_ARMED : DET_SETTLING;
        end
        DET_SETTLING: begin
          if (settle_done(settle_cnt)) begin
            det_state <= DET_ARMED;
          end else begin
            settle_cnt <= settle_cnt + 32'h1;
          end
        end
        DET_ARMED: begin
          settle_cnt <= settle_cnt;
        end
        default: begin
          det_state <= DET_OFF;
        end
      endcase
    end
  end

  // ready is the armed state; a disable drops it on the next edge
  assign reference_ready_flag = (det_state == DET_ARMED);

  // event flag sticks; hardware set wins over a software clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      periph_flag_reg_two <= 8'h00;
    end else begin
      if (wr_flags) begin
        periph_flag_reg_two <= reg_wdata_i;
      end
      if (event_set) begin
        periph_flag_reg_two[vdet_pkg::EVENT_BIT] <= 1'b1;
      end
    end
  end

  // peripheral enables, written whole
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      periph_enable_reg_two <= 8'h00;
    end else if (wr_enables) begin
      periph_enable_reg_two <= reg_wdata_i;
    end
  end

  // core interrupt control, global and peripheral gates
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      core_interrupt_control <= 8'h00;
    end else if (wr_core) begin
      core_interrupt_control <= reg_wdata_i;
    end
  end

  // local interrupt mask, only the implemented bits are kept
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= reg_wdata_i[vdet_pkg::ST_W-1:0];
    end
  end

  // sticky local status, write one to clear, set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      status <= '0;
    end else begin
      ready_q <= reference_ready_flag;
      for (int i = 0; i < vdet_pkg::ST_W; i++) begin
        if (wr_status && reg_wdata_i[i]) begin
          status[i] <= 1'b0;
        end
      end
      if (event_set) begin
        status[vdet_pkg::ST_EVENT] <= 1'b1;
      end
      if (ready_rise) begin
        status[vdet_pkg::ST_READY] <= 1'b1;
      end
    end
  end
  assign ready_rise = reference_ready_flag && !ready_q;

  // request to the core, registered; all three gates must be open
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      voltage_event_req_o <= 1'b0;
    end else begin
      voltage_event_req_o <=
        periph_flag_reg_two[vdet_pkg::EVENT_BIT] &&
        periph_enable_reg_two[vdet_pkg::EVENT_BIT] &&
        core_interrupt_control[vdet_pkg::PERIPH_BIT] &&
        core_interrupt_control[vdet_pkg::GLOBAL_BIT];
    end
  end

  // local interrupt, high while an unmasked status bit is set
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // analog controls, registered
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      detector_power_enable_o <= 1'b0;
      trip_level_field_o <= 4'h0;
      external_select_o <= 1'b0;
      excursion_direction_select_o <= 1'b0;
    end else begin
      detector_power_enable_o <= power_en;
      trip_level_field_o <= level;
      external_select_o <= is_external(level);
      excursion_direction_select_o <= direction;
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        vdet_pkg::ADDR_CONTROL: begin
          reg_rdata_o <= control_view(voltage_detect_control,
                                      reference_ready_flag);
        end
        vdet_pkg::ADDR_FLAGS: reg_rdata_o <= periph_flag_reg_two;
        vdet_pkg::ADDR_ENABLES: reg_rdata_o <= periph_enable_reg_two;
        vdet_pkg::ADDR_CORE: reg_rdata_o <= core_interrupt_control;
        vdet_pkg::ADDR_STATUS: reg_rdata_o <= {6'h00, status};
        vdet_pkg::ADDR_MASK: reg_rdata_o <= {6'h00, mask};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule : supply_excursion_detector

// File: rtl/vdet_pkg.sv
// constants for the supply excursion detector
package vdet_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_FLAGS = 3'h1;
  localparam logic [2:0] ADDR_ENABLES = 3'h2;
  localparam logic [2:0] ADDR_CORE = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_MASK = 3'h5;
  // control register fields
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam int POWER_BIT = 4;
  localparam int READY_BIT = 5;
  localparam int UNUSED_BIT = 6;
  localparam int DIR_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h05;
  localparam logic [7:0] CONTROL_WMASK = 8'h9F;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  // flag / enable / core interrupt fields
  localparam int EVENT_BIT = 2;
  localparam int GLOBAL_BIT = 7;
  localparam int PERIPH_BIT = 6;
  // local status / mask fields
  localparam int ST_EVENT = 0;
  localparam int ST_READY = 1;
  localparam int ST_W = 2;
  // reference settle time
  localparam int SETTLE_NS = 20000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
endpackage : vdet_pkg

// File: rtl/vdet_sync.sv
// two-flop synchroniser for the comparator result
`timescale 1ns/1ps
module vdet_sync (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // async level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : vdet_sync

// File: test/vdet_front.sv
// comparator front end model facing the detector
`timescale 1ns/1ps
module vdet_front (
  // controls from the detector
  input wire logic power_i,
  input wire logic ext_sel_i,
  // 1 = supply at or above the trip point
  input wire logic above_i,
  // comparator results
  output logic trip_o,
  output logic ext_o
);
  // dead or unselected paths show the opposite level, never a copy
  assign trip_o = (power_i && !ext_sel_i) ? above_i : !above_i;
  assign ext_o = (power_i && ext_sel_i) ? above_i : !above_i;
endmodule : vdet_front

// File: test/vdet_properties.sv
// port assertions for the supply excursion detector
`timescale 1ns/1ps
module vdet_properties (
  // clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // front end and request
  input wire logic detector_power_enable_o,
  input wire logic [3:0] trip_level_field_o,
  input wire logic external_select_o,
  input wire logic excursion_direction_select_o,
  input wire logic voltage_event_req_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic ctl_wr = reg_wr_i && reg_addr_i == vdet_pkg::ADDR_CONTROL;
  wire logic ctl_rd = reg_rd_i && reg_addr_i == vdet_pkg::ADDR_CONTROL;
  a_spare_bit_zero: assert property ($past(ctl_rd) |-> !reg_rdata_o[6])
    else $error("spare control bit read high");
  a_power_copy: assert property (ctl_wr |-> ##2
    detector_power_enable_o == $past(reg_wdata_i[4], 2))
    else $error("power output differs from write");
  a_dir_copy: assert property (ctl_wr |-> ##2
    excursion_direction_select_o == $past(reg_wdata_i[7], 2))
    else $error("direction output differs from write");
  a_level_copy: assert property (ctl_wr |-> ##2
    trip_level_field_o == $past(reg_wdata_i[3:0], 2))
    else $error("level output differs from write");
  a_ext_route: assert property (ctl_wr |-> ##2 external_select_o ==
    ($past(reg_wdata_i[3:0], 2) == vdet_pkg::LEVEL_EXTERNAL))
    else $error("external select wrong for level");
  a_ready_after_on: assert property ($past(ctl_rd) && reg_rdata_o[5]
    |-> $past(detector_power_enable_o, 2))
    else $error("ready seen without power");
  a_req_sticky: assert property (voltage_event_req_o && !reg_wr_i
    && !$past(reg_wr_i) |=> voltage_event_req_o)
    else $error("request dropped without a write");
  a_event_needs_on: assert property ($rose(voltage_event_req_o)
    && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> $past(detector_power_enable_o, 2))
    else $error("event set while detector off");
endmodule : vdet_properties
bind supply_excursion_detector vdet_properties u_props (.*);

// File: test/supply_excursion_detector_tb.sv
// self-checking bench for the supply excursion detector
`timescale 1ns/1ps
module supply_excursion_detector_tb;
  localparam int SETTLE = 40;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic above = 1'b1;
  logic [7:0] reg_rdata_o, ctl;
  logic trip_cmp, ext_cmp, pwr, ext_sel, req, irq, dir;
  logic [3:0] lvl;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  supply_excursion_detector #(.SETTLE_CYCLES(SETTLE)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .trip_compare_i(trip_cmp),
    .ext_compare_i(ext_cmp), .detector_power_enable_o(pwr),
    .trip_level_field_o(lvl), .external_select_o(ext_sel),
    .excursion_direction_select_o(dir), .voltage_event_req_o(req),
    .irq_o(irq));
  vdet_front u_front (.power_i(pwr), .ext_sel_i(ext_sel), .above_i(above),
    .trip_o(trip_cmp), .ext_o(ext_cmp));
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, exp);
    @(posedge sys_clk_i);
  endtask : rd
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // cut a hang short well past the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(vdet_pkg::ADDR_CONTROL, vdet_pkg::CONTROL_RESET);
    rd(3'h7, 8'h00);
    wr(vdet_pkg::ADDR_CONTROL, 8'hFF);
    rd(vdet_pkg::ADDR_CONTROL, 8'h9F);
    repeat (SETTLE) @(posedge sys_clk_i);
    rd(vdet_pkg::ADDR_CONTROL, 8'hBF);
    wr(vdet_pkg::ADDR_CONTROL, 8'h8F);
    rd(vdet_pkg::ADDR_CONTROL, 8'h8F);
    $display("control register test done");
    // falling watch on an internal tap, then rising on the external pin
    for (int d = 0; d < 2; d++) begin
      ctl = d ? 8'h8F : 8'h03;
      above <= !d[0];
      wr(vdet_pkg::ADDR_CONTROL, ctl);
      wr(vdet_pkg::ADDR_CONTROL, ctl | 8'h10);
      wr(vdet_pkg::ADDR_FLAGS, 8'h00);
      wr(vdet_pkg::ADDR_STATUS, 8'h03);
      wr(vdet_pkg::ADDR_ENABLES, 8'h04);
      wr(vdet_pkg::ADDR_CORE, 8'hC0);
      wr(vdet_pkg::ADDR_MASK, 8'h01);
      above <= d[0];
      repeat (5) @(posedge sys_clk_i);
      above <= !d[0];
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check({6'h00, req, irq}, 8'h00);
      @(posedge sys_clk_i);
      repeat (SETTLE) @(posedge sys_clk_i);
      above <= d[0];
      repeat (6) @(posedge sys_clk_i);
      above <= !d[0];
      @(negedge sys_clk_i);
      check({6'h00, req, irq}, 8'h03);
      check({dir, 3'h0, lvl}, ctl & 8'h8F);
      check({7'h00, ext_sel}, {7'h00, d[0]});
      @(posedge sys_clk_i);
      rd(vdet_pkg::ADDR_FLAGS, 8'h04);
      wr(vdet_pkg::ADDR_MASK, 8'h00);
      @(negedge sys_clk_i);
      check({6'h00, req, irq}, 8'h02);
      @(posedge sys_clk_i);
      wr(vdet_pkg::ADDR_CORE, 8'h40);
      @(negedge sys_clk_i);
      check({7'h00, req}, 8'h00);
      @(posedge sys_clk_i);
      wr(vdet_pkg::ADDR_CONTROL, ctl);
      wr(vdet_pkg::ADDR_FLAGS, 8'h00);
      wr(vdet_pkg::ADDR_STATUS, 8'h03);
      rd(vdet_pkg::ADDR_CONTROL, ctl);
      $display("event test done, direction %0d", d);
    end
    complete_run();
  end
endmodule : supply_excursion_detector_tb
